// ===== common/sccs_regs.svh
`ifndef SCCS_REGS_SVH
`define SCCS_REGS_SVH
`define SCCS_CLK_HZ      40000000
`define SCCS_OSC_LOW_HZ  128000
`define SCCS_OSC_HIGH_HZ 2560000
`define SCCS_POR_TICKS   1024
`define SCCS_ACT_TICKS   384
`define SCCS_T_UNIT      64
`define SCCS_IO_AT       (17 * `SCCS_T_UNIT / 2)
`define SCCS_RST_AT      (23 * `SCCS_T_UNIT / 2)
`define SCCS_DR_RST      (3 * `SCCS_T_UNIT / 64)
`define SCCS_DR_CLK      (`SCCS_DR_RST + `SCCS_T_UNIT / 2)
`define SCCS_DR_IO       (`SCCS_DR_RST + `SCCS_T_UNIT)
`define SCCS_DR_VCC      (`SCCS_DR_RST + 3 * `SCCS_T_UNIT / 2)
`define SCCS_DEB_TICKS   640
`define SCCS_VCC5_MS     30
`define SCCS_VCC3_MS     15
`define SCCS_OC_MS       2
`define SCCS_DET_TICKS   4
`define SCCS_DET_EDGES   8
`define SCCS_SEL_DELAY   10
`define SCCS_IO_TD_NS    500
`define SCCS_IO_PU_NS    200
`define SCCS_MS_TICKS(ms) ((ms) * `SCCS_OSC_LOW_HZ / 1000)
`define SCCS_NS_CYC(ns)  (((ns) * (`SCCS_CLK_HZ / 1000000) + 999) / 1000)
`endif

// ===== common/sccs_pkg.sv
package sccs_pkg;
  // session sequencer states, one-hot
  typedef enum logic [5:0] {
    SCCS_POR    = 6'h01,
    SCCS_SHUT   = 6'h02,
    SCCS_ARM    = 6'h04,
    SCCS_RAMP   = 6'h08,
    SCCS_ACTIVE = 6'h10,
    SCCS_DEACT  = 6'h20
  } sccs_seq_t;
  // io repeater states, one-hot
  typedef enum logic [3:0] {
    SCCS_IO_IDLE  = 4'h1,
    SCCS_IO_DELAY = 4'h2,
    SCCS_IO_DRIVE = 4'h4,
    SCCS_IO_PU    = 4'h8
  } sccs_io_t;
  // card clock ratio, one-hot
  typedef enum logic [2:0] {
    SCCS_DIV1 = 3'h1,
    SCCS_DIV2 = 3'h2,
    SCCS_DIV4 = 3'h4
  } sccs_div_t;
endpackage

// ===== src/sccs_clk_div.sv
`timescale 1ns/1ps
`include "sccs_regs.svh"
module sccs_clk_div import sccs_pkg::*; #(
  parameter bit FAST_VARIANT = 1'h0  // low select gives undivided clock
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic ref_rise,        // synchronised input clock rising
  input  wire logic ref_fall,        // synchronised input clock falling
  input  wire logic divide_select,   // synchronised select level
  input  wire logic run,             // clock applied to the card
  output logic      card_clk
);
  // ****************************************
  // ratio selection
  // ****************************************
  logic [3:0] sel_cnt;               // input clocks since select moved
  logic       sel_seen;              // last sampled select
  logic       sel_eff;               // select after the settle delay
  sccs_div_t  mode;                  // ratio in force
  logic       ph;                    // divide-by-four phase
  wire sccs_div_t want = sel_eff ? SCCS_DIV2 : (FAST_VARIANT ? SCCS_DIV1 : SCCS_DIV4);
  // a change only counts once it has held for the settle delay
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sel_cnt  <= 4'h0;
      sel_seen <= 1'h1;
      sel_eff  <= 1'h1;
    end else if (divide_select != sel_seen) begin
      sel_seen <= divide_select;
      sel_cnt  <= 4'h0;
    end else if (ref_rise && sel_eff != sel_seen) begin
      if (sel_cnt == 4'(`SCCS_SEL_DELAY - 1)) begin
        sel_eff <= sel_seen;
      end
      sel_cnt <= sel_cnt + 4'h1;
    end
  end
  // ****************************************
  // output generation
  // ****************************************
  // switching only after a complete low phase keeps every pulse whole
  wire boundary = ~card_clk && (mode != SCCS_DIV4 || ph);
  always_ff @(posedge clk_sys) begin
    if (srst || !run) begin
      card_clk <= 1'h0;
      ph       <= 1'h0;
      mode     <= want;
    end else if (ref_rise && boundary) begin
      mode     <= want;
      card_clk <= 1'h1;
      ph       <= 1'h0;
    end else if (ref_rise) begin
      // even counts of input edges give a balanced duty cycle
      if (mode == SCCS_DIV2) begin
        card_clk <= ~card_clk;
      end else if (mode == SCCS_DIV4) begin
        ph <= ~ph;
        if (ph) begin
          card_clk <= ~card_clk;
        end
      end
    end else if (ref_fall && mode == SCCS_DIV1) begin
      card_clk <= 1'h0;
    end
  end
endmodule // sccs_clk_div

// ===== src/sccs_sequencer.sv
`timescale 1ns/1ps
`include "sccs_regs.svh"
module sccs_sequencer import sccs_pkg::*; #(
  parameter int LOW_DIV      = `SCCS_CLK_HZ / `SCCS_OSC_LOW_HZ,
  parameter int HIGH_DIV     = `SCCS_CLK_HZ / `SCCS_OSC_HIGH_HZ,
  parameter bit FAST_VARIANT = 1'h0
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic logic_supply_ok,
  input  wire logic regulator_input_supply_ok,
  input  wire logic host_interface_supply_ok,
  input  wire logic overcurrent_raw,
  input  wire logic overtemp_raw,
  input  wire logic session_command_n,
  input  wire logic card_present_n,
  input  wire logic host_card_reset_in,
  input  wire logic card_clock_divide_select,
  input  wire logic ref_clock_in,
  input  wire logic host_side_io_i,
  output logic      host_side_io_o,
  output logic      host_side_io_oe,
  input  wire logic card_io_i,
  output logic      card_io_o,
  output logic      card_io_oe,
  output logic      card_vcc_en,
  output logic      card_vcc_5v,
  output logic      card_rst,
  output logic      card_clk,
  output logic      osc_high_mode,
  output logic      crystal_osc_en,
  output logic      fault_presence_out_n,
  output logic      session_active
);
  // ****************************************
  // input synchronisers
  // ****************************************
  localparam int NIN = 11;
  logic [NIN-1:0] sync1;             // first stage, read by sync2 only
  logic [NIN-1:0] sync2;             // stable copies
  wire  [NIN-1:0] raw_in = {logic_supply_ok, regulator_input_supply_ok,
                            host_interface_supply_ok, overcurrent_raw, overtemp_raw,
                            session_command_n, card_present_n, host_card_reset_in,
                            card_clock_divide_select, ref_clock_in, host_side_io_i};
  // every pin passes two flops, the monitors too
  // host io stage resets to its idle high level so no false edge follows reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync1 <= NIN'(1);
      sync2 <= NIN'(1);
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end
  wire s_logic_ok = sync2[10];
  wire s_regulator_input_supply_ok  = sync2[9];
  wire s_intf_ok  = sync2[8];
  wire s_oc       = sync2[7];
  wire s_otemp    = sync2[6];
  wire s_cmd_n    = sync2[5];
  wire s_pres_n   = sync2[4];
  wire s_hrst     = sync2[3];
  wire s_dsel     = sync2[2];
  wire s_ref      = sync2[1];
  wire s_host_io  = sync2[0];
  // card io sampled separately, its pin is not always ours
  logic card_io_s1;                  // first stage
  logic card_io_s2;                  // stable copy
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      card_io_s1 <= 1'h1;
      card_io_s2 <= 1'h1;
    end else begin
      card_io_s1 <= card_io_i;
      card_io_s2 <= card_io_s1;
    end
  end
  // ****************************************
  // edge detection
  // ****************************************
  logic cmd_q;                       // delayed command
  logic ref_q;                       // delayed input clock
  logic host_io_q;                   // delayed host io
  logic card_io_q;                   // delayed card io
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmd_q     <= 1'h0;
      ref_q     <= 1'h0;
      host_io_q <= 1'h1;
      card_io_q <= 1'h1;
    end else begin
      cmd_q     <= s_cmd_n;
      ref_q     <= s_ref;
      host_io_q <= s_host_io;
      card_io_q <= card_io_s2;
    end
  end
  wire cmd_fall  = cmd_q & ~s_cmd_n;
  wire ref_rise  = ~ref_q & s_ref;
  wire ref_fall  = ref_q & ~s_ref;
  wire host_fall = host_io_q & ~s_host_io;
  wire card_fall = card_io_q & ~card_io_s2;
  // ****************************************
  // oscillator tick enables
  // ****************************************
  // both rates always tick; the high rate is only used while the mode says so
  logic [15:0] low_cnt;              // low-rate divider
  logic [15:0] high_cnt;             // high-rate divider
  wire low_tick  = (low_cnt == 16'(LOW_DIV - 1));
  wire high_tick = (high_cnt == 16'(HIGH_DIV - 1));
  always_ff @(posedge clk_sys) begin
    if (srst || low_tick) begin
      low_cnt <= 16'h0;
    end else begin
      low_cnt <= low_cnt + 16'h1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst || high_tick) begin
      high_cnt <= 16'h0;
    end else begin
      high_cnt <= high_cnt + 16'h1;
    end
  end
  // count compare shared by the count-up timers; the detection window counts down and tests for one
  function automatic logic reached(input logic [15:0] c, input int n);
    return c >= 16'(n);
  endfunction
  // ****************************************
  // presence debounce
  // ****************************************
  logic [15:0] deb_cnt;              // stable-low ticks
  logic        pres_deb;             // debounced card present
  always_ff @(posedge clk_sys) begin
    if (srst || s_pres_n) begin
      deb_cnt  <= 16'h0;
      pres_deb <= 1'h0;
    end else if (low_tick && !pres_deb) begin
      deb_cnt <= deb_cnt + 16'h1;
      if (reached(deb_cnt, `SCCS_DEB_TICKS - 1)) begin
        pres_deb <= 1'h1;
      end
    end
  end
  // ****************************************
  // overcurrent filter
  // ****************************************
  // spikes shorter than the window are let through on purpose
  logic [15:0] oc_cnt;               // overload ticks
  wire oc_flt = reached(oc_cnt, `SCCS_MS_TICKS(`SCCS_OC_MS));
  always_ff @(posedge clk_sys) begin
    if (srst || !s_oc) begin
      oc_cnt <= 16'h0;
    end else if (low_tick && !oc_flt) begin
      oc_cnt <= oc_cnt + 16'h1;
    end
  end
  // ****************************************
  // card supply voltage choice
  // ****************************************
  logic [15:0] hi_cnt;               // ticks with command high
  always_ff @(posedge clk_sys) begin
    if (srst || !s_cmd_n) begin
      hi_cnt <= 16'h0;
    end else if (low_tick && !reached(hi_cnt, `SCCS_MS_TICKS(`SCCS_VCC5_MS))) begin
      hi_cnt <= hi_cnt + 16'h1;
    end
  end
  // between the two limits the last choice is kept
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      card_vcc_5v <= 1'h0;
    end else if (cmd_fall && reached(hi_cnt, `SCCS_MS_TICKS(`SCCS_VCC5_MS))) begin
      card_vcc_5v <= 1'h1;
    end else if (cmd_fall && !reached(hi_cnt, `SCCS_MS_TICKS(`SCCS_VCC3_MS))) begin
      card_vcc_5v <= 1'h0;
    end
  end
  // ****************************************
  // clock source detection
  // ****************************************
  // only as good as the host: the clock must be running before the fall
  logic [3:0] det_ticks;             // window left
  logic [7:0] det_edges;             // input clock edges seen
  wire det_busy = (det_ticks != 4'h0);
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      det_ticks      <= 4'h0;
      det_edges      <= 8'h0;
      crystal_osc_en <= 1'h0;
    end else if (cmd_fall) begin
      det_ticks <= 4'(`SCCS_DET_TICKS);
      det_edges <= 8'h0;
    end else if (det_busy) begin
      if (ref_rise && det_edges != 8'hFF) begin
        det_edges <= det_edges + 8'h1;
      end
      if (low_tick) begin
        det_ticks <= det_ticks - 4'h1;
        if (det_ticks == 4'h1) begin
          crystal_osc_en <= (det_edges < 8'(`SCCS_DET_EDGES));
        end
      end
    end
  end
  // ****************************************
  // session sequencer
  // ****************************************
  sccs_seq_t   state;                // sequencer state
  sccs_seq_t   next_state;
  logic [15:0] seq_cnt;              // ticks in current state; RAMP and ACTIVE share one count
  logic        next_clr;             // restart the state timer
  logic        vcc_on;               // card supply on
  logic        io_on;                // card io released
  logic        clk_on;               // card clock running
  logic        rst_en;               // card reset follows host
  logic        fault_latch;          // session fault seen
  logic        fault_presence_out_n_arm;             // command has been high once
  logic        osc_hi;               // fast oscillator wanted
  wire in_sess = (state == SCCS_ARM) || (state == SCCS_RAMP) || (state == SCCS_ACTIVE);
  wire fault = in_sess && (oc_flt || s_otemp || !s_regulator_input_supply_ok || !s_intf_ok
                           || !s_logic_ok || !pres_deb);
  wire seq_tick = (state == SCCS_RAMP || state == SCCS_DEACT) ? high_tick : low_tick;
  // next state; supply loss and faults share the deactivation path
  always_comb begin
    next_state = state;
    next_clr   = 1'h0;
    case (state)
      SCCS_POR: begin
        if (!s_logic_ok) begin
          next_clr = 1'h1;
        end else if (reached(seq_cnt, `SCCS_POR_TICKS)) begin
          next_state = SCCS_SHUT;
          next_clr   = 1'h1;
        end
      end
      SCCS_SHUT: begin
        if (!s_logic_ok) begin
          next_state = SCCS_POR;
          next_clr   = 1'h1;
        end else if (cmd_fall && pres_deb && s_regulator_input_supply_ok && s_intf_ok) begin
          next_state = SCCS_ARM;
          next_clr   = 1'h1;
        end
      end
      SCCS_ARM: begin
        if (fault || s_cmd_n) begin
          next_state = SCCS_DEACT;
          next_clr   = 1'h1;
        end else if (reached(seq_cnt, `SCCS_ACT_TICKS)) begin
          next_state = SCCS_RAMP;
          next_clr   = 1'h1;
        end
      end
      SCCS_RAMP: begin
        if (fault || s_cmd_n) begin
          next_state = SCCS_DEACT;
          next_clr   = 1'h1;
        end else if (reached(seq_cnt, `SCCS_RST_AT)) begin
          next_state = SCCS_ACTIVE;
        end
      end
      SCCS_ACTIVE: begin
        if (fault || s_cmd_n) begin
          next_state = SCCS_DEACT;
          next_clr   = 1'h1;
        end
      end
      SCCS_DEACT: begin
        if (reached(seq_cnt, `SCCS_DR_VCC)) begin
          next_state = SCCS_SHUT;
          next_clr   = 1'h1;
        end
      end
      default: begin
        next_state = SCCS_POR;
        next_clr   = 1'h1;
      end
    endcase
  end
  // state and timer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state   <= SCCS_POR;
      seq_cnt <= 16'h0;
    end else begin
      state <= next_state;
      if (next_clr) begin
        seq_cnt <= 16'h0;
      end else if (seq_tick && seq_cnt != 16'hFFFF) begin
        seq_cnt <= seq_cnt + 16'h1;
      end
    end
  end
  // contact enables step up on activation and down on deactivation; a deactivation from ARM switches the supply on until SCCS_DR_VCC
  wire next_vcc_on = (state == SCCS_RAMP) || (state == SCCS_ACTIVE)
                     || (state == SCCS_DEACT && !reached(seq_cnt, `SCCS_DR_VCC));
  wire next_io_on  = (state == SCCS_RAMP && reached(seq_cnt, `SCCS_IO_AT))
                     || (state == SCCS_ACTIVE)
                     || (state == SCCS_DEACT && io_on && !reached(seq_cnt, `SCCS_DR_IO));
  wire next_clk_on = (state == SCCS_RAMP && reached(seq_cnt, `SCCS_IO_AT))
                     || (state == SCCS_ACTIVE)
                     || (state == SCCS_DEACT && clk_on && !reached(seq_cnt, `SCCS_DR_CLK));
  wire next_rst_en = (state == SCCS_ACTIVE)
                     || (state == SCCS_DEACT && rst_en && !reached(seq_cnt, `SCCS_DR_RST));
  // fast rate exactly while the card supply is up, so both move together
  wire next_osc_hi = (state == SCCS_RAMP) || (state == SCCS_ACTIVE)
                     || (state == SCCS_DEACT && !reached(seq_cnt, `SCCS_DR_VCC));
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      vcc_on        <= 1'h0;
      io_on         <= 1'h0;
      clk_on        <= 1'h0;
      rst_en        <= 1'h0;
      osc_hi        <= 1'h0;
    end else begin
      vcc_on        <= next_vcc_on;
      io_on         <= next_io_on;
      clk_on        <= next_clk_on;
      rst_en        <= next_rst_en;
      osc_hi        <= next_osc_hi;
    end
  end
  // card-facing outputs, all low when the sequence is down
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      card_vcc_en    <= 1'h0;
      card_rst       <= 1'h0;
      session_active <= 1'h0;
      osc_high_mode  <= 1'h0;
    end else begin
      card_vcc_en    <= vcc_on;
      osc_high_mode  <= osc_hi;
      card_rst       <= rst_en & s_hrst;
      session_active <= in_sess;
    end
  end
  // ****************************************
  // fault / presence output
  // ****************************************
  // arm not cleared by a supply dip, only by the block reset; the fault latch also clears in shutdown with command high
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fault_presence_out_n_arm    <= 1'h0;
      fault_latch <= 1'h0;
    end else begin
      if (s_cmd_n) begin
        fault_presence_out_n_arm <= 1'h1;
      end
      if (fault) begin
        fault_latch <= 1'h1;
      end else if (state == SCCS_SHUT && s_cmd_n) begin
        fault_latch <= 1'h0;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fault_presence_out_n <= 1'h0;
    end else begin
      fault_presence_out_n <= fault_presence_out_n_arm && pres_deb && !fault_latch && !fault;
    end
  end
  // ****************************************
  // card clock
  // ****************************************
  // input clock is sampled, so it must stay well below half of clk_sys
  sccs_clk_div #(
    .FAST_VARIANT (FAST_VARIANT)
  ) u_div (
    .clk_sys       (clk_sys),
    .srst          (srst),
    .ref_rise      (ref_rise),
    .ref_fall      (ref_fall),
    .divide_select (s_dsel),
    .run           (clk_on),
    .card_clk      (card_clk)
  );
  // ****************************************
  // io repeater
  // ****************************************
  localparam int TD_CYC = `SCCS_NS_CYC(`SCCS_IO_TD_NS);
  localparam int PU_CYC = `SCCS_NS_CYC(`SCCS_IO_PU_NS);
  sccs_io_t   io_st;                 // repeater state
  sccs_io_t   next_io_st;
  logic       master_card;           // card side is master
  logic [7:0] io_cnt;                // delay timer
  wire master_lvl = master_card ? card_io_s2 : s_host_io;
  // the slave side edge is ignored while a transfer runs
  always_comb begin
    next_io_st = io_st;
    case (io_st)
      SCCS_IO_IDLE: begin
        if (io_on && (host_fall || card_fall)) begin
          next_io_st = SCCS_IO_DELAY;
        end
      end
      SCCS_IO_DELAY: begin
        if (reached({8'h0, io_cnt}, TD_CYC - 1)) begin
          next_io_st = SCCS_IO_DRIVE;
        end
      end
      SCCS_IO_DRIVE: begin
        if (master_lvl) begin
          next_io_st = SCCS_IO_PU;
        end
      end
      SCCS_IO_PU: begin
        if (reached({8'h0, io_cnt}, PU_CYC - 1)) begin
          next_io_st = SCCS_IO_IDLE;
        end
      end
      default: begin
        next_io_st = SCCS_IO_IDLE;
      end
    endcase
    if (!io_on) begin
      next_io_st = SCCS_IO_IDLE;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      io_st       <= SCCS_IO_IDLE;
      master_card <= 1'h0;
      io_cnt      <= 8'h0;
    end else begin
      io_st <= next_io_st;
      if (io_st == SCCS_IO_IDLE) begin
        master_card <= card_fall && !host_fall;
      end
      io_cnt <= (next_io_st != io_st) ? 8'h0 : io_cnt + 8'h1;
    end
  end
  // slave is pulled low during drive, pushed high for the pull-up pulse
  wire drv   = (io_st == SCCS_IO_DRIVE) || (io_st == SCCS_IO_PU);
  wire drv_v = (io_st == SCCS_IO_PU);
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      host_side_io_o  <= 1'h0;
      host_side_io_oe <= 1'h0;
      card_io_o       <= 1'h0;
      card_io_oe      <= 1'h1;
    end else begin
      host_side_io_o  <= drv_v;
      host_side_io_oe <= drv && master_card;
      card_io_o       <= drv_v && io_on;
      card_io_oe      <= !io_on || (drv && !master_card);
    end
  end
endmodule // sccs_sequencer

// ===== test/sccs_card_model.sv
`timescale 1ns/1ps
// ****************************************
// card and external clock source
// ****************************************
module sccs_card_model (
  input  wire logic card_io_o,
  input  wire logic card_io_oe,
  input  wire logic pull_low,
  output logic      card_io_i,
  output logic      ref_clock_in
);
  // wired line: driver wins, else card low, else pull-up
  assign card_io_i = card_io_oe ? card_io_o : !pull_low;
  // external clock runs free from time zero, ahead of any command
  initial begin
    ref_clock_in = 1'h0;
    forever #100 ref_clock_in = ~ref_clock_in;
  end
endmodule // sccs_card_model

// ===== test/sccs_seq_sva.sv
`timescale 1ns/1ps
// ****************************************
// port checker for the session sequencer
// ****************************************
module sccs_seq_sva #(
  parameter int LOW_DIV = 4
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic session_active,
  input wire logic osc_high_mode,
  input wire logic card_vcc_en,
  input wire logic card_rst,
  input wire logic card_clk,
  input wire logic card_io_o,
  input wire logic card_io_oe,
  input wire logic card_present_n,
  input wire logic host_card_reset_in,
  input wire logic fault_presence_out_n
);
  int unsigned up_cnt; // cycles since reset, saturating
  always_ff @(posedge clk_sys) begin
    if (srst) up_cnt <= 0;
    else if (up_cnt < 32'h00100000) up_cnt <= up_cnt + 1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_pulled; card_present_n [*4]; endsequence
  sequence s_rst_low; !host_card_reset_in [*5]; endsequence
  por_hold_a: assert property (up_cnt < 1024 * LOW_DIV |-> !session_active)
    else $error("session during power-on wait");
  idle_osc_a: assert property (!card_vcc_en |-> !osc_high_mode)
    else $error("oscillator fast while card off");
  ramp_pair_a: assert property ($rose(card_vcc_en) |-> osc_high_mode)
    else $error("supply up before fast oscillator");
  rst_in_vcc_a: assert property (card_rst |-> card_vcc_en)
    else $error("card reset without supply");
  io_first_a: assert property ($fell(card_vcc_en) |-> $past(card_io_oe) && !$past(card_rst))
    else $error("supply dropped before io and reset");
  ground_a: assert property (!card_vcc_en |-> card_io_oe && !card_io_o && !card_clk)
    else $error("contacts not grounded");
  absent_a: assert property (s_pulled ##2 1 |-> !fault_presence_out_n)
    else $error("status high without card");
  extract_a: assert property (session_active ##0 s_pulled |-> ##[0:400] !card_vcc_en)
    else $error("no deactivation on extraction");
  rst_follow_a: assert property (s_rst_low |-> !card_rst)
    else $error("card reset ignores host");
endmodule // sccs_seq_sva

// ===== test/tb_sccs_sequencer.sv
`timescale 1ns/1ps
// ****************************************
// session sequencer bench
// ****************************************
module tb_sccs_sequencer;
  logic clk_sys, srst, logic_supply_ok, regulator_input_supply_ok, host_interface_supply_ok;
  logic overcurrent_raw, overtemp_raw, session_command_n, card_present_n, host_card_reset_in;
  logic card_clock_divide_select, ref_clock_in, host_side_io_o, host_side_io_oe, card_io_i;
  logic card_io_o, card_io_oe, card_vcc_en, card_vcc_5v, card_rst, card_clk, osc_high_mode;
  logic crystal_osc_en, fault_presence_out_n, session_active, pull_low;
  wire logic host_side_io_i;
  int   err_total, check_count, cyc, n, r;
  // host line idles high through its pull-up
  assign host_side_io_i = host_side_io_oe ? host_side_io_o : 1'h1;
  sccs_sequencer #(.LOW_DIV(4), .HIGH_DIV(2), .FAST_VARIANT(1'h0)) i_sccs_sequencer (.*);
  sccs_card_model i_sccs_card_model (.*);
  initial begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'h1) begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // bounded wait for a level, returns cycles taken
  task automatic wait_on(ref logic s, input logic v, input int lim, output int k);
    k = 0;
    while (s !== v && k < lim) begin
      @(negedge clk_sys);
      k++;
    end
    chk(s === v, "level not reached");
  endtask
  // card clock rising edges over a window
  task automatic rises(input int c, output int k);
    logic p;
    k = 0;
    p = card_clk;
    repeat (c) begin
      @(negedge clk_sys);
      if (card_clk && !p) k++;
      p = card_clk;
    end
  endtask
  task automatic results();
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard, whole run needs about 15k cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      results();
    end
  end
  initial begin
    {srst, logic_supply_ok, regulator_input_supply_ok, host_interface_supply_ok} = 4'hF;
    {overcurrent_raw, overtemp_raw, card_present_n, host_card_reset_in, pull_low} = 5'h00;
    session_command_n = 1'h1;
    card_clock_divide_select = 1'h1;
    repeat (10) @(negedge clk_sys);
    srst = 1'h0;
    repeat (2000) @(negedge clk_sys);
    chk(!fault_presence_out_n && !session_active, "early status");
    repeat (5000) @(negedge clk_sys);
    chk(fault_presence_out_n === 1'h1, "no presence");
    session_command_n = 1'h0;
    wait_on(card_vcc_en, 1'h1, 2000, n);
    chk(n >= 1530 && n <= 1550, "supply timing");
    // shortened window sees only two source edges, below the count: crystal starts
    chk(osc_high_mode && crystal_osc_en && !card_vcc_5v, "clock or volt");
    wait_on(card_io_oe, 1'h0, 1200, n);
    chk(n >= 1080 && n <= 1100, "io timing");
    rises(400, r);
    chk(r >= 24 && r <= 26, "half rate");
    card_clock_divide_select = 1'h0;
    repeat (120) @(negedge clk_sys);
    rises(400, r);
    chk(r >= 12 && r <= 13, "quarter rate");
    repeat (500) @(negedge clk_sys);
    host_card_reset_in = 1'h1;
    repeat (6) @(negedge clk_sys);
    chk(card_rst === 1'h1, "reset follow");
    pull_low = 1'h1;
    repeat (30) @(negedge clk_sys);
    chk(host_side_io_oe && !host_side_io_o && !card_io_oe, "copy low");
    pull_low = 1'h0;
    repeat (6) @(negedge clk_sys);
    chk(host_side_io_oe && host_side_io_o, "pull-up");
    repeat (12) @(negedge clk_sys);
    chk(host_side_io_oe === 1'h0, "idle");
    card_present_n = 1'h1;
    wait_on(card_vcc_en, 1'h0, 400, n);
    chk(!card_rst && card_io_oe && !card_clk && !osc_high_mode, "deact");
    chk(fault_presence_out_n === 1'h0, "extract status");
    session_command_n = 1'h1;
    card_present_n = 1'h0;
    repeat (3000) @(negedge clk_sys);
    chk(fault_presence_out_n === 1'h1, "recheck");
    results();
  end
endmodule // tb_sccs_sequencer
bind sccs_sequencer sccs_seq_sva #(.LOW_DIV(LOW_DIV)) i_sccs_seq_sva (.*);
